/* File: bench/owd_checker_assertions.sv */
// Concurrent checks on the option word decoder ports.
`timescale 1ns/10ps
`include "owd_consts.vh"
module owd_checker #(
	parameter WIDTH = 13
) (
	// Clock and reset
	input wire             pclk,
	input wire             presetn,
	// APB
	input wire             psel,
	input wire             penable,
	input wire             pwrite,
	input wire [7:0]       paddr,
	input wire             pready,
	input wire [31:0]      prdata,
	// Options
	input wire             instr_period_select,
	input wire             watchdog_enable,
	input wire             rc_clock_mode,
	input wire             fast_crystal_mode,
	input wire             slow_crystal_mode,
	input wire             drive_power_select,
	input wire             code_protect,
	input wire [WIDTH-1:0] customer_code,
	input wire             instr_cycle_tick,
	input wire             timer_counter_tick
);
	reg  [1:0] seen_r;
	wire       rd_st = psel && penable && pready && !pwrite && paddr == `OWD_OFS_STATUS;
	wire [2:0] mode = {slow_crystal_mode, fast_crystal_mode, rc_clock_mode};
	wire       tick = instr_cycle_tick;

	// Counts edges after reset so that the load edge is excluded from hold checks.
	always @(posedge pclk or negedge presetn) begin
		if (!presetn)
			seen_r <= 2'h0;
		else if (seen_r != 2'h2)
			seen_r <= seen_r + 2'h1;
	end

	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);

	mode_onehot_a:
		assert property (seen_r != 2'h0 |-> $onehot(mode)) else $error("mode not one-hot");
	tick_same_a:
		assert property (timer_counter_tick == tick) else $error("timer tick differs");
	tick_two_a:
		assert property (tick && !instr_period_select |=> !tick ##1 tick) else $error("tick not 2");
	tick_four_a:
		assert property (tick && instr_period_select |=> !tick [*3] ##1 tick)
		else $error("tick not 4");
	opts_hold_a:
		assert property (seen_r == 2'h2 |-> $stable({mode, instr_period_select, watchdog_enable,
			drive_power_select, code_protect, customer_code})) else $error("options moved");
	st_protect_a:
		assert property (rd_st |-> prdata[`OWD_ST_PROTECT] == code_protect)
		else $error("status protect wrong");
	st_wdt_a:
		assert property (rd_st |-> prdata[`OWD_ST_WDT_EN] == watchdog_enable)
		else $error("status watchdog wrong");
	st_osc_a:
		assert property (rd_st |-> prdata[`OWD_ST_SLOW:`OWD_ST_RC] == mode)
		else $error("status mode wrong");
endmodule // owd_checker

bind owd_option_decoder owd_checker #(.WIDTH(WIDTH)) u_chk (.pclk, .presetn, .psel, .penable,
	.pwrite, .paddr, .pready, .prdata, .instr_period_select, .watchdog_enable, .rc_clock_mode,
	.fast_crystal_mode, .slow_crystal_mode, .drive_power_select, .code_protect, .customer_code,
	.instr_cycle_tick, .timer_counter_tick);

/* File: bench/owd_programmer.sv */
// Programming-side model: an APB master that burns and reads the option words.
`timescale 1ns/10ps
module owd_programmer (
	// Clock
	input  wire        pclk,
	// APB request
	output reg         psel,
	output reg         penable,
	output reg         pwrite,
	output reg  [7:0]  paddr,
	output reg  [31:0] pwdata,
	// APB answer
	input  wire        pready,
	input  wire [31:0] prdata,
	input  wire        pslverr
);
	initial begin
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0000_0000;
	end

	// Holds the request until pready is seen, takes the answer at that edge, then idles.
	task xfer(input wr, input [7:0] a, input [31:0] d, output [31:0] rd, output err);
		begin
			@(posedge pclk);
			psel <= 1'b1;
			penable <= 1'b0;
			pwrite <= wr;
			paddr <= a;
			pwdata <= d;
			@(posedge pclk);
			penable <= 1'b1;
			@(posedge pclk);
			while (!pready)
				@(posedge pclk);
			rd = prdata;
			err = pslverr;
			psel <= 1'b0;
			penable <= 1'b0;
			paddr <= ~a;
			pwdata <= ~d;
		end
	endtask
endmodule // owd_programmer

/* File: bench/testbench.sv */
// Self-checking bench for the option word decoder.
`timescale 1ns/10ps
`include "owd_consts.vh"
`define CHK(a, e) begin cmp_count = cmp_count + 1; if ((a) !== (e)) begin \
	mismatches = mismatches + 1; $display("[FAIL] %0t got %h exp %h", $time, a, e); end end
module testbench;
	reg         pclk = 1'b0;
	reg         presetn = 1'b0;
	reg         ce = 1'b1;
	wire        psel, penable, pwrite, pready, pslverr;
	wire [7:0]  paddr;
	wire [31:0] pwdata, prdata;
	wire        ips, wde, rcm, fcm, scm, dps, cpr, ict, tct;
	wire [12:0] cust;
	integer     mismatches = 0, cmp_count = 0, cyc = 0, i, n;
	reg  [31:0] rd;
	reg         err;
	reg  [12:0] w;
	reg  [12:0] stg [0:2];

	owd_programmer prg (.pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr));
	owd_option_decoder #(.WIDTH(13)) DUT (.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
		.prdata(prdata), .pslverr(pslverr), .instr_period_select(ips), .watchdog_enable(wde),
		.rc_clock_mode(rcm), .fast_crystal_mode(fcm), .slow_crystal_mode(scm),
		.drive_power_select(dps), .code_protect(cpr), .customer_code(cust),
		.instr_cycle_tick(ict), .timer_counter_tick(tct));

	initial begin
		forever #10 pclk = ~pclk;
	end

	task close_out;
		begin
			$display("comparisons %0d mismatches %0d", cmp_count, mismatches);
			if (mismatches == 0 && cmp_count > 0)
				$display("ALL TESTS PASSED");
			else
				$display("TESTS FAILED");
			$finish;
		end
	endtask

	always @(posedge pclk) begin
		cyc = cyc + 1;
		if (cyc == 20000) begin
			mismatches = mismatches + 1;
			close_out;
		end
	end

	task do_reset;
		begin
			presetn <= 1'b0;
			repeat (6) @(posedge pclk);
			presetn <= 1'b1;
			repeat (3) @(posedge pclk);
		end
	endtask

	// Compares every decoded output and the status word with the burnt option word.
	task check_opts(input [12:0] v, input [12:0] c);
		begin
			`CHK(ips, v[8])
			`CHK(wde, ~v[7])
			`CHK({rcm, fcm, scm}, {~v[4], v[4] & v[5], v[4] & ~v[5]})
			`CHK(dps, v[3])
			`CHK(cpr, ~&v[2:0])
			`CHK(cust, c)
			prg.xfer(1'b0, `OWD_OFS_STATUS, 32'h0000_0000, rd, err);
			`CHK(rd[8:0], {2'h2, ~&v[2:0], v[3], v[4] & ~v[5], v[4] & v[5], ~v[4], ~v[7], v[8]})
			@(posedge pclk);
			while (!ict) @(posedge pclk);
			n = 1;
			@(posedge pclk);
			while (!ict && n < 10) begin
				@(posedge pclk);
				n = n + 1;
			end
			`CHK(n, v[8] ? 4 : 2)
		end
	endtask

	initial begin
		stg[0] = 13'h1FDE;
		stg[1] = 13'h1E56;
		stg[2] = 13'h1E46;
		do_reset;
		check_opts(13'h1FFF, 13'h1FFF);
		prg.xfer(1'b0, `OWD_OFS_WORD0, 32'h0000_0000, rd, err);
		`CHK({err, rd}, 33'h0_0000_0000)
		prg.xfer(1'b1, `OWD_OFS_STATUS, 32'h0000_0001, rd, err);
		`CHK(err, 1'b1)
		prg.xfer(1'b0, 8'h10, 32'h0000_0000, rd, err);
		`CHK({err, rd}, 33'h1_0000_0000)
		for (i = 0; i < 3; i = i + 1) begin
			w = stg[i];
			prg.xfer(1'b1, `OWD_OFS_CTRL, 32'h0000_0001, rd, err);
			prg.xfer(1'b1, `OWD_OFS_WORD0, {19'h0_0000, w & ~`OWD_RSVD_MASK}, rd, err);
			prg.xfer(1'b1, `OWD_OFS_WORD1, 32'h0000_0A5A, rd, err);
			prg.xfer(1'b0, `OWD_OFS_WORD0, 32'h0000_0000, rd, err);
			`CHK(rd, {19'h0_0000, w})
			prg.xfer(1'b0, `OWD_OFS_WORD1, 32'h0000_0000, rd, err);
			`CHK(rd, 32'h0000_0A5A)
			do_reset;
			check_opts(w, 13'h0A5A);
		end
		close_out;
	end
endmodule // testbench

/* File: rtl/owd_consts.vh */
// Constants for the option word decoder: offsets, fields, reset values and counts.
`ifndef OWD_CONSTS_VH
`define OWD_CONSTS_VH

// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define OWD_OFS_CTRL        8'h00
`define OWD_OFS_WORD0       8'h04
`define OWD_OFS_WORD1       8'h08
`define OWD_OFS_STATUS      8'h0C

// ----------------------------------------------------------------
// Option word field positions
// ----------------------------------------------------------------
`define OWD_WORD_W          13
`define OWD_BIT_PERIOD      8
`define OWD_BIT_WDT_N       7
`define OWD_BIT_RANGE       5
`define OWD_BIT_OSC         4
`define OWD_BIT_POWER       3
`define OWD_PROT_HI         2
`define OWD_PROT_LO         0
`define OWD_RSVD_MASK       13'h1E40
`define OWD_PROT_OPEN       3'h7

// ----------------------------------------------------------------
// Control and status fields
// ----------------------------------------------------------------
`define OWD_CTRL_PROG       0
`define OWD_ST_PERIOD       0
`define OWD_ST_WDT_EN       1
`define OWD_ST_RC           2
`define OWD_ST_FAST         3
`define OWD_ST_SLOW         4
`define OWD_ST_POWER        5
`define OWD_ST_PROTECT      6
`define OWD_ST_PROG         7
`define OWD_ST_LOADED       8

// ----------------------------------------------------------------
// Reset values and cycle counts
// ----------------------------------------------------------------
`define OWD_ERASED          13'h1FFF
`define OWD_CTRL_RST        1'b0
`define OWD_DIV_SHORT       2'h1
`define OWD_DIV_LONG        2'h3

`endif

/* File: rtl/owd_option_decoder.v */
// Option word decoder with an APB programming port and latched option outputs.
//
// Our own choices: the register addresses and the APB slave port.
`timescale 1ns/10ps
`include "owd_consts.vh"

module owd_option_decoder #(
	parameter WIDTH = 13
) (
	// Clock, reset and enable
	input  wire             pclk,
	input  wire             presetn,
	input  wire             ce,
	// APB programming port
	input  wire             psel,
	input  wire             penable,
	input  wire             pwrite,
	input  wire [7:0]       paddr,
	input  wire [31:0]      pwdata,
	output wire             pready,
	output wire [31:0]      prdata,
	output wire             pslverr,
	// Decoded options
	output wire             instr_period_select,
	output wire             watchdog_enable,
	output wire             rc_clock_mode,
	output wire             fast_crystal_mode,
	output wire             slow_crystal_mode,
	output wire             drive_power_select,
	output wire             code_protect,
	output wire [WIDTH-1:0] customer_code,
	// Derived clock enables
	output wire             instr_cycle_tick,
	output wire             timer_counter_tick
);

	// ----------------------------------------------------------------
	// Declarations
	// ----------------------------------------------------------------
	reg              prog_en_r;
	reg              loaded_r;
	reg              period_r;
	reg              wdt_en_r;
	reg              rc_r;
	reg              fast_r;
	reg              slow_r;
	reg              power_r;
	reg              protect_r;
	reg  [WIDTH-1:0] cust_r;
	reg  [1:0]       div_cnt_r;
	reg  [1:0]       div_cnt_nxt;
	reg              tick_r;
	reg              tick_nxt;
	reg              rd_valid_r;
	reg  [31:0]      prdata_r;
	reg  [31:0]      rdata_nxt;
	reg              slverr_r;
	reg              map_hit;
	wire             setup_ph;
	wire             access_ph;
	wire             wr_done;
	wire             burn_en;
	wire             burn_idx;
	wire [WIDTH-1:0] word0;
	wire [WIDTH-1:0] word1;
	wire [WIDTH-1:0] opt_word;
	wire [2:0]       prot_bits;
	wire [1:0]       div_last;
	wire [31:0]      status_word;

	// ----------------------------------------------------------------
	// Word storage
	// ----------------------------------------------------------------
	// Both words live in their own array, apart from any program store.
	owd_store #(
		.WORDS     (2),
		.WIDTH     (WIDTH)
	) u_store (
		.pclk      (pclk),
		.presetn   (presetn),
		.ce        (ce),
		.burn_en   (burn_en),
		.burn_idx  (burn_idx),
		.burn_data (pwdata[WIDTH-1:0]),
		.word0     (word0),
		.word1     (word1)
	);

	// ----------------------------------------------------------------
	// APB phases
	// ----------------------------------------------------------------
	assign setup_ph  = psel & ~penable;
	assign access_ph = psel & penable;

	// The answer comes once the read data has been captured in setup.
	assign pready  = access_ph & ce & rd_valid_r;
	assign wr_done = pready & pwrite;
	assign prdata  = prdata_r;
	assign pslverr = pready & slverr_r;

	// Words can only be burned while programming mode is open.
	assign burn_en  = wr_done & ~slverr_r & prog_en_r &
		((paddr == `OWD_OFS_WORD0) | (paddr == `OWD_OFS_WORD1));
	assign burn_idx = (paddr == `OWD_OFS_WORD1);

	always @* begin
		case (paddr)
			`OWD_OFS_CTRL,
			`OWD_OFS_WORD0,
			`OWD_OFS_WORD1: map_hit = 1'b1;
			`OWD_OFS_STATUS: map_hit = ~pwrite;
			default: map_hit = 1'b0;
		endcase
	end

	// ----------------------------------------------------------------
	// Read data
	// ----------------------------------------------------------------
	assign status_word = {23'h00_0000,
		loaded_r, prog_en_r, protect_r, power_r,
		slow_r, fast_r, rc_r, wdt_en_r, period_r};

	always @* begin
		rdata_nxt = 32'h0000_0000;
		case (paddr)
			`OWD_OFS_CTRL: begin
				rdata_nxt[`OWD_CTRL_PROG] = prog_en_r;
			end
			`OWD_OFS_WORD0: begin
				// Readback only through the programming mode, never to the core.
				if (prog_en_r) begin
					rdata_nxt[WIDTH-1:0] = word0 | `OWD_RSVD_MASK;
				end
			end
			`OWD_OFS_WORD1: begin
				if (prog_en_r) begin
					rdata_nxt[WIDTH-1:0] = word1;
				end
			end
			`OWD_OFS_STATUS: begin
				rdata_nxt = status_word;
			end
			default: begin
				rdata_nxt = 32'h0000_0000;
			end
		endcase
	end

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata_r   <= 32'h0000_0000;
			slverr_r   <= 1'b0;
			rd_valid_r <= 1'b0;
		end else if (ce) begin
			if (setup_ph) begin
				prdata_r   <= pwrite ? 32'h0000_0000 : rdata_nxt;
				slverr_r   <= ~map_hit;
				rd_valid_r <= 1'b1;
			end else if (pready) begin
				rd_valid_r <= 1'b0;
			end
		end
	end

	// ----------------------------------------------------------------
	// Control register
	// ----------------------------------------------------------------
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prog_en_r <= `OWD_CTRL_RST;
		end else if (ce && wr_done && !slverr_r && (paddr == `OWD_OFS_CTRL)) begin
			prog_en_r <= pwdata[`OWD_CTRL_PROG];
		end
	end

	// ----------------------------------------------------------------
	// Option decode
	// ----------------------------------------------------------------
	assign opt_word  = word0 | `OWD_RSVD_MASK;
	assign prot_bits = opt_word[`OWD_PROT_HI:`OWD_PROT_LO];

	// Decoded outputs are loaded once after reset release and then frozen,
	// so a burn during operation only shows after the next reset.
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			loaded_r  <= 1'b0;
			period_r  <= 1'b0;
			wdt_en_r  <= 1'b0;
			rc_r      <= 1'b0;
			fast_r    <= 1'b0;
			slow_r    <= 1'b0;
			power_r   <= 1'b0;
			protect_r <= 1'b1;
			cust_r    <= {WIDTH{1'b0}};
		end else if (ce && !loaded_r) begin
			loaded_r  <= 1'b1;
			period_r  <= opt_word[`OWD_BIT_PERIOD];
			wdt_en_r  <= ~opt_word[`OWD_BIT_WDT_N];
			rc_r      <= ~opt_word[`OWD_BIT_OSC];
			// The range bit is ignored for the RC type.
			fast_r    <= opt_word[`OWD_BIT_OSC] & opt_word[`OWD_BIT_RANGE];
			slow_r    <= opt_word[`OWD_BIT_OSC] & ~opt_word[`OWD_BIT_RANGE];
			power_r   <= opt_word[`OWD_BIT_POWER];
			protect_r <= (prot_bits != `OWD_PROT_OPEN);
			cust_r    <= word1;
		end
	end

	assign instr_period_select = period_r;
	assign watchdog_enable     = wdt_en_r;
	assign rc_clock_mode       = rc_r;
	assign fast_crystal_mode   = fast_r;
	assign slow_crystal_mode   = slow_r;
	assign drive_power_select  = power_r;
	assign code_protect        = protect_r;
	assign customer_code       = cust_r;

	// ----------------------------------------------------------------
	// Instruction cycle and timer source divider
	// ----------------------------------------------------------------
	// One tick per instruction cycle; the timer source shares it.
	assign div_last = period_r ? `OWD_DIV_LONG : `OWD_DIV_SHORT;

	always @* begin
		div_cnt_nxt = div_cnt_r + 2'h1;
		tick_nxt    = 1'b0;
		if (div_cnt_r >= div_last) begin
			div_cnt_nxt = 2'h0;
			tick_nxt    = 1'b1;
		end
	end

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			div_cnt_r <= 2'h0;
			tick_r    <= 1'b0;
		end else if (ce) begin
			if (!loaded_r) begin
				div_cnt_r <= 2'h0;
				tick_r    <= 1'b0;
			end else begin
				div_cnt_r <= div_cnt_nxt;
				tick_r    <= tick_nxt;
			end
		end
	end

	assign instr_cycle_tick   = tick_r;
	assign timer_counter_tick = tick_r;

endmodule // owd_option_decoder

/* File: rtl/owd_store.v */
// Non-program storage for the two thirteen-bit configuration words.
`timescale 1ns/10ps
`include "owd_consts.vh"

module owd_store #(
	parameter WORDS = 2,
	parameter WIDTH = 13
) (
	// Clock, reset and enable
	input  wire             pclk,
	input  wire             presetn,
	input  wire             ce,
	// Burn port from the programming side
	input  wire             burn_en,
	input  wire             burn_idx,
	input  wire [WIDTH-1:0] burn_data,
	// Stored words
	output wire [WIDTH-1:0] word0,
	output wire [WIDTH-1:0] word1
);

	// ----------------------------------------------------------------
	// Word cells
	// ----------------------------------------------------------------
	// A burn can only clear bits of an erased word, as a one-time cell does.
	// The cells are not touched by reset: burnt options must survive it so that
	// the decoder can load them on the next reset release. Only power-up finds
	// them erased, so presetn is deliberately left unused here.
	wire [WORDS*WIDTH-1:0] cells;

	genvar i;
	generate
		for (i = 0; i < WORDS; i = i + 1) begin : g_word
			reg  [WIDTH-1:0] cell_r;
			wire [WIDTH-1:0] keep_mask;
			assign keep_mask = (i == 0) ? `OWD_RSVD_MASK : {WIDTH{1'b0}};
			initial begin
				cell_r = `OWD_ERASED;
			end
			always @(posedge pclk) begin
				if (ce && burn_en && (burn_idx == i)) begin
					// Reserved positions of word 0 stay at one.
					cell_r <= cell_r & (burn_data | keep_mask);
				end
			end
			assign cells[i*WIDTH +: WIDTH] = cell_r;
		end
	endgenerate

	assign word0 = cells[WIDTH-1:0];
	assign word1 = cells[2*WIDTH-1:WIDTH];

endmodule // owd_store
